// ==== vml_pkg.sv ====
/*
 vml_pkg: constants shared by the vector memory port.
 assumes one processor clock; no other dependencies.
*/
package vml_pkg;
    // ----------------------------------------------------------------
    // opcode layout
    // ----------------------------------------------------------------
    localparam logic [6:0] VML_OP_LOAD = 7'h7E;   // major code 176 octal
    localparam logic [6:0] VML_OP_STORE = 7'h7F;  // major code 177 octal
    localparam logic [2:0] VML_SEL_STRIDED = 3'h0; // selector digit 0
    localparam logic [2:0] VML_SEL_INDEXED = 3'h1; // selector digit 1
    localparam logic [2:0] VML_DESIG_UNIT = 3'h0;  // stride designator zero
    localparam int VML_OP_HI = 15;                 // major code field
    localparam int VML_OP_LO = 9;
    localparam int VML_I_HI = 8;                   // i designator field
    localparam int VML_I_LO = 6;
    localparam int VML_J_HI = 5;                   // j designator field
    localparam int VML_J_LO = 3;
    localparam int VML_K_HI = 2;                   // k designator field
    localparam int VML_K_LO = 0;
    // ----------------------------------------------------------------
    // data path sizes
    // ----------------------------------------------------------------
    localparam int VML_WORD_W = 64;       // element width
    localparam int VML_ADDR_W = 24;       // memory address width
    localparam int VML_IDX_W = 24;        // signed index field width
    localparam int VML_ELEMS = 64;        // elements per vector register
    localparam int VML_VL_W = 7;          // vector length 0..64
    localparam int VML_EL_W = 6;          // element index
    localparam logic [VML_ADDR_W-1:0] VML_UNIT_STEP = 24'h000001;

    // ----------------------------------------------------------------
    // sequencer states, gray along idle-run-drain-done
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        VML_IDLE = 2'b00,
        VML_RUN = 2'b01,
        VML_DRAIN = 2'b11,
        VML_DONE = 2'b10
    } vml_state_type;
endpackage : vml_pkg

// ==== vml_addr_gen.sv ====
/*
 vml_addr_gen: per-element address formation for the vector memory port.
 assumes caller holds base, stride and index steady while in use.
*/
`timescale 1ns/1ps
`default_nettype none
module vml_addr_gen (
    input wire logic indexed_in,                           // gather/scatter mode
    input wire logic first_in,                             // first element of strided run
    input wire logic [vml_pkg::VML_ADDR_W-1:0] base_in,    // base address
    input wire logic [vml_pkg::VML_ADDR_W-1:0] run_in,     // running strided address
    input wire logic [vml_pkg::VML_ADDR_W-1:0] step_in,    // signed stride
    input wire logic [vml_pkg::VML_WORD_W-1:0] index_in,   // index element
    output logic [vml_pkg::VML_ADDR_W-1:0] addr_out,       // address of this element
    output logic [vml_pkg::VML_ADDR_W-1:0] next_run_out    // running address after it
);
    import vml_pkg::*;
    // ----------------------------------------------------------------
    // address arithmetic
    // ----------------------------------------------------------------
    logic [VML_ADDR_W-1:0] offset; // sign-extended index, wraps at width
    logic [VML_ADDR_W-1:0] strided; // current strided address

    // low index bits sign-extended; modulo sum truncates to the bus
    always_comb begin
        offset = VML_ADDR_W'($signed(index_in[VML_IDX_W-1:0]));
        strided = first_in ? base_in : run_in;
        addr_out = indexed_in ? VML_ADDR_W'(base_in + offset) : strided;
        next_run_out = VML_ADDR_W'(strided + step_in);
    end
endmodule : vml_addr_gen
`default_nettype wire

// ==== vml_vector_port.sv ====
/*
 vml_vector_port: vector load/store port moving words between memory and
 one 64-element vector register, strided or indexed.
 assumes the issue logic holds its inputs while start is taken and memory
 returns load data in request order with a valid strobe.
*/
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - strided load starts at base address
// - stride is signed, steps either way
// - load designator zero means unit step
// - strided load moves vector length elements
// - gather walks elements from zero upward
// - gather address is base plus index
// - gather moves vector length words
// - strided store starts at base address
// - stride added after every stored word
// - store designator zero means unit step
// - scatter walks source elements from zero
// - scatter address is base plus index
// - stores write vector length elements
// - decode load/store and strided/indexed
module vml_vector_port (
    input wire logic clk_in,                                           // processor clock
    input wire logic reset_n_in,                                       // async reset, active low
    input wire logic start_in,                                         // issue strobe
    input wire logic [15:0] instr_in,                                  // instruction word
    input wire logic [vml_pkg::VML_ADDR_W-1:0] base_address_reg_in,    // base address
    input wire logic [vml_pkg::VML_ADDR_W-1:0] stride_reg_in,          // stride
    input wire logic [vml_pkg::VML_VL_W-1:0] vector_length_reg_in,     // element count
    input wire logic [vml_pkg::VML_WORD_W-1:0] store_source_vector_in, // source element
    input wire logic [vml_pkg::VML_WORD_W-1:0] index_vector_in,        // index element
    input wire logic mem_ack_in,                                       // memory accepts request
    input wire logic mem_rvalid_in,                                    // load data valid
    input wire logic [vml_pkg::VML_WORD_W-1:0] mem_rdata_in,           // load data
    output logic busy_out,                                             // transfer in progress
    output logic done_out,                                             // one-cycle completion
    output logic [vml_pkg::VML_EL_W-1:0] src_elem_out,                 // element read index
    output logic mem_req_out,                                          // memory request
    output logic mem_we_out,                                           // write request
    output logic [vml_pkg::VML_ADDR_W-1:0] mem_addr_out,               // memory address
    output logic [vml_pkg::VML_WORD_W-1:0] mem_wdata_out,              // store data
    output logic load_dest_we_out,                                     // destination write
    output logic [vml_pkg::VML_EL_W-1:0] load_dest_elem_out,           // destination element
    output logic [vml_pkg::VML_WORD_W-1:0] load_dest_data_out          // destination data
);
    import vml_pkg::*;

    // ----------------------------------------------------------------
    // decode of the issued instruction
    // ----------------------------------------------------------------
    logic [6:0] op; // major code, top seven bits of the parcel
    logic [2:0] sel; // selector, i designator for stores, j designator for loads
    logic [2:0] desig_k; // stride/index designator
    logic is_load; // load major code
    logic is_store; // store major code
    logic is_idx; // indexed addressing
    logic valid_op; // recognised instruction

    // store selector sits in i field; load selector in j field
    always_comb begin
        op = instr_in[VML_OP_HI:VML_OP_LO];
        desig_k = instr_in[VML_K_HI:VML_K_LO];
        is_load = (op == VML_OP_LOAD);
        is_store = (op == VML_OP_STORE);
        sel = is_store ? instr_in[VML_I_HI:VML_I_LO] : instr_in[VML_J_HI:VML_J_LO];
        is_idx = (sel == VML_SEL_INDEXED);
        valid_op = (is_load || is_store) && (is_idx || sel == VML_SEL_STRIDED);
    end

    // ----------------------------------------------------------------
    // transfer context, captured at issue
    // ----------------------------------------------------------------
    vml_state_type state_r; // sequencer state
    logic store_r; // store transfer
    logic idx_r; // indexed transfer
    logic first_r; // next request is element zero
    logic [VML_ADDR_W-1:0] base_r; // base address copy
    logic [VML_ADDR_W-1:0] step_r; // signed step
    logic [VML_ADDR_W-1:0] run_r; // running strided address
    logic [VML_VL_W-1:0] len_r; // elements to move
    logic [VML_VL_W-1:0] req_cnt_r; // requests accepted
    logic [VML_VL_W-1:0] rsp_cnt_r; // load words returned
    logic [VML_ADDR_W-1:0] elem_addr; // address of current element
    logic [VML_ADDR_W-1:0] next_run; // running address after it
    logic take; // request accepted this cycle
    logic last_req; // the accepted request is the final one

    assign take = mem_req_out && mem_ack_in;
    assign last_req = take && (VML_VL_W'(req_cnt_r + 1'b1) == len_r);

    // context load; zero designator replaces stride by one
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            store_r <= 1'b0;
            idx_r <= 1'b0;
            base_r <= '0;
            step_r <= '0;
            len_r <= '0;
        end else if (state_r == VML_IDLE && start_in && valid_op) begin
            store_r <= is_store;
            idx_r <= is_idx;
            base_r <= base_address_reg_in;
            step_r <= (desig_k == VML_DESIG_UNIT) ? VML_UNIT_STEP : stride_reg_in;
            len_r <= vector_length_reg_in;
        end
    end

    // ----------------------------------------------------------------
    // address generation
    // ----------------------------------------------------------------
    vml_addr_gen u_addr (
        .indexed_in(idx_r),
        .first_in(first_r),
        .base_in(base_r),
        .run_in(run_r),
        .step_in(step_r),
        .index_in(index_vector_in),
        .addr_out(elem_addr),
        .next_run_out(next_run)
    );

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    // loads wait in drain until every word is back; zero length ends at once
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_r <= VML_IDLE;
        end else begin
            unique case (state_r)
                VML_IDLE: begin
                    if (start_in && valid_op) begin
                        state_r <= (vector_length_reg_in == '0) ? VML_DONE : VML_RUN;
                    end
                end
                VML_RUN: begin
                    if (last_req) begin
                        state_r <= store_r ? VML_DONE : VML_DRAIN;
                    end
                end
                VML_DRAIN: begin
                    if (rsp_cnt_r == len_r) begin
                        state_r <= VML_DONE;
                    end
                end
                VML_DONE: begin
                    state_r <= VML_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // request side: counter, running address, held request
    // ----------------------------------------------------------------
    // elements go out in order from zero, one per accepted request
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            req_cnt_r <= '0;
            first_r <= 1'b1;
            run_r <= '0;
        end else if (state_r == VML_IDLE) begin
            req_cnt_r <= '0;
            first_r <= 1'b1;
        end else if (take) begin
            req_cnt_r <= VML_VL_W'(req_cnt_r + 1'b1);
            first_r <= 1'b0;
            run_r <= next_run;
        end
    end

    // request registered; held steady until memory acks it
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mem_req_out <= 1'b0;
            mem_we_out <= 1'b0;
            mem_addr_out <= '0;
            mem_wdata_out <= '0;
        end else if (!mem_req_out || mem_ack_in) begin
            // issue the next element only after the registered one is taken
            if (state_r == VML_RUN && !last_req && !(mem_req_out == 1'b0 && req_cnt_r == len_r)) begin
                mem_req_out <= 1'b1;
                mem_we_out <= store_r;
                mem_addr_out <= take ? addr_next_elem(next_run) : elem_addr;
                mem_wdata_out <= store_source_vector_in;
            end else begin
                mem_req_out <= 1'b0;
                mem_we_out <= 1'b0;
            end
        end
    end

    // element fed to the source ports: the one after the current request
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            src_elem_out <= '0;
        end else if (state_r == VML_IDLE) begin
            src_elem_out <= '0;
        end else if ((!mem_req_out || mem_ack_in) && state_r == VML_RUN && !last_req) begin
            src_elem_out <= VML_EL_W'(src_elem_out + 1'b1);
        end
    end

    // address for the element after an accepted one: next strided address, or base plus index when indexed
    function automatic logic [VML_ADDR_W-1:0] addr_next_elem(input logic [VML_ADDR_W-1:0] nr);
        addr_next_elem = idx_r ? elem_addr : nr;
    endfunction : addr_next_elem

    // ----------------------------------------------------------------
    // load return path
    // ----------------------------------------------------------------
    // returned words land in consecutive destination elements
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rsp_cnt_r <= '0;
            load_dest_we_out <= 1'b0;
            load_dest_elem_out <= '0;
            load_dest_data_out <= '0;
        end else begin
            load_dest_we_out <= 1'b0;
            if (state_r == VML_IDLE) begin
                rsp_cnt_r <= '0;
            end else if (mem_rvalid_in && !store_r && rsp_cnt_r != len_r) begin
                load_dest_we_out <= 1'b1;
                load_dest_elem_out <= VML_EL_W'(rsp_cnt_r);
                load_dest_data_out <= mem_rdata_in;
                rsp_cnt_r <= VML_VL_W'(rsp_cnt_r + 1'b1);
            end
        end
    end

    // ----------------------------------------------------------------
    // status
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            busy_out <= 1'b0;
            done_out <= 1'b0;
        end else begin
            busy_out <= (state_r == VML_IDLE) ? (start_in && valid_op) : (state_r != VML_DONE);
            done_out <= (state_r == VML_DONE);
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    chk_req_held: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_addr_out) && $stable(mem_we_out))
        else $error("request dropped or changed before acceptance");
    chk_count_limit: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        state_r != VML_IDLE |-> req_cnt_r <= len_r)
        else $error("more requests than vector length");
    chk_done_count: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        state_r == VML_DONE |-> req_cnt_r == len_r)
        else $error("done with wrong element count");
    chk_load_count: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        state_r == VML_DONE && !store_r |-> rsp_cnt_r == len_r)
        else $error("load done before all words returned");
    chk_done_pulse: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        done_out |=> !done_out)
        else $error("done longer than one cycle");
    chk_first_base: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        $rose(mem_req_out) && req_cnt_r == '0 && !idx_r |-> mem_addr_out == base_r)
        else $error("first strided address not base");
    chk_stride_step: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        take && !idx_r && state_r == VML_RUN ##1 mem_req_out |-> mem_addr_out == VML_ADDR_W'($past(mem_addr_out, 1) + step_r))
        else $error("stride not applied");
    chk_idle_quiet: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        state_r == VML_IDLE && !(start_in && valid_op) |=> !mem_req_out)
        else $error("request without valid instruction");
endmodule : vml_vector_port
`default_nettype wire

// ==== vml_mem_model.sv ====
/*
 vml_mem_model: behavioural central memory facing the vector memory port.
 assumes the port holds each request until ack and asks at most once a cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module vml_mem_model (
    input wire logic clk_in,           // processor clock
    input wire logic reset_n_in,       // sync reset, active low, sampled just after the edge
    input wire logic slow_in,          // stall acks at random, stretch latency
    input wire logic req_in,           // request from the port
    input wire logic we_in,            // write request
    input wire logic [23:0] addr_in,   // request address
    output logic ack_out,              // request accepted this cycle
    output logic rvalid_out,           // read data strobe
    output logic [63:0] rdata_out      // read data
);
    // ----------------------------------------------------------------
    // read return queue, strictly in acceptance order
    // ----------------------------------------------------------------
    logic [63:0] rq[$];  // words waiting to return
    int due[$];          // cycle from which each word may return
    int cyc = 0;         // free-running cycle count

    initial begin
        ack_out = 1'b0;
        rvalid_out = 1'b0;
        rdata_out = 64'h0;
    end

    // accept on the edge, answer just after it like any bus party
    always @(posedge clk_in) begin
        if (req_in && ack_out && !we_in) begin
            rq.push_back({16'hD00D, ~addr_in, addr_in});
            due.push_back(cyc + (slow_in ? 4 : 2));
        end
        cyc++;
        #1;
        if (!reset_n_in) begin
            rq.delete();
            due.delete();
        end
        // slow mode acks roughly one cycle in three
        ack_out = reset_n_in && req_in && (!slow_in || ($urandom % 3 == 0));
        if (rq.size() > 0 && due[0] <= cyc) begin
            rvalid_out = 1'b1;
            rdata_out = rq.pop_front();
            void'(due.pop_front());
        end else begin
            // idle data toggles so a stale word is never mistaken for valid
            rvalid_out = 1'b0;
            rdata_out = ~rdata_out;
        end
    end
endmodule : vml_mem_model
`default_nettype wire

// ==== testbench.sv ====
/*
 testbench: self-checking bench for vml_vector_port with a memory model.
 assumes vml_pkg, vml_vector_port and vml_mem_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import vml_pkg::*;
    // ----------------------------------------------------------------
    // stimulus and observed signals
    // ----------------------------------------------------------------
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic start_in = 1'b0;
    logic slow = 1'b0;          // memory stall mode
    logic [15:0] instr_in = 16'h0000;
    logic [23:0] base_in = 24'h0, stride_in = 24'h0;
    logic [6:0] vl_in = 7'h00;
    logic [63:0] src_vec[64], idx_vec[64];  // source and index registers
    logic busy_out, done_out, mem_req_out, mem_we_out, load_dest_we_out;
    logic mem_ack_in, mem_rvalid_in;
    logic [5:0] src_elem_out, load_dest_elem_out;
    logic [23:0] mem_addr_out;
    logic [63:0] mem_wdata_out, load_dest_data_out, mem_rdata_in;
    // reference model queues, filled per operation
    logic [23:0] exp_addr[$];
    logic [63:0] exp_data[$];
    logic exp_we = 1'b0;
    int n_acc = 0, ld_n = 0, error_cnt = 0, n_compared = 0, test_no = 0;

    always #20 clk_in = ~clk_in;  // 25 MHz

    vml_vector_port i_dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .start_in(start_in),
        .instr_in(instr_in), .base_address_reg_in(base_in), .stride_reg_in(stride_in),
        .vector_length_reg_in(vl_in), .store_source_vector_in(src_vec[src_elem_out]),
        .index_vector_in(idx_vec[src_elem_out]), .mem_ack_in(mem_ack_in),
        .mem_rvalid_in(mem_rvalid_in), .mem_rdata_in(mem_rdata_in), .busy_out(busy_out),
        .done_out(done_out), .src_elem_out(src_elem_out), .mem_req_out(mem_req_out),
        .mem_we_out(mem_we_out), .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out),
        .load_dest_we_out(load_dest_we_out), .load_dest_elem_out(load_dest_elem_out),
        .load_dest_data_out(load_dest_data_out));
    vml_mem_model i_mem (.clk_in(clk_in), .reset_n_in(reset_n_in), .slow_in(slow),
        .req_in(mem_req_out), .we_in(mem_we_out), .addr_in(mem_addr_out), .ack_out(mem_ack_in),
        .rvalid_out(mem_rvalid_in), .rdata_out(mem_rdata_in));

    // ----------------------------------------------------------------
    // checking and verdict
    // ----------------------------------------------------------------
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic results;
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results

    // every accepted request and every destination write against the model
    always @(posedge clk_in) begin
        if (reset_n_in && mem_req_out && mem_ack_in) begin
            n_acc++;
            check(mem_we_out, exp_we);
            check(mem_addr_out, exp_addr.pop_front());
            if (exp_we) begin
                check(mem_wdata_out, exp_data.pop_front());
            end
        end
        if (reset_n_in && load_dest_we_out) begin
            check(load_dest_elem_out, ld_n[5:0]);
            check(load_dest_data_out, exp_data.pop_front());
            ld_n++;
        end
    end

    // one operation: build expectations, issue, wait, count
    task automatic run_op(input bit st, input bit ix, input logic [2:0] k,
                          input logic [23:0] base, input logic [23:0] stride, input int vl, input bit slow_m);
        logic [23:0] a;
        int w;
        test_no++;
        for (w = 0; w < 64; w++) begin
            src_vec[w] = {$urandom, $urandom};
            idx_vec[w] = {$urandom, $urandom};
        end
        exp_we = st;
        n_acc = 0;
        ld_n = 0;
        a = base;
        for (w = 0; w < vl; w++) begin
            if (ix) begin
                a = base + idx_vec[w][23:0];
            end else if (w > 0) begin
                a = a + ((k == 3'h0) ? 24'h000001 : stride);
            end
            exp_addr.push_back(a);
            exp_data.push_back(st ? src_vec[w] : {16'hD00D, ~a, a});
        end
        @(posedge clk_in);
        #1;
        slow = slow_m;
        base_in = base;
        stride_in = stride;
        vl_in = 7'(vl);
        instr_in = st ? {VML_OP_STORE, {2'b00, ix}, 3'h3, k} : {VML_OP_LOAD, 3'h2, {2'b00, ix}, k};
        start_in = 1'b1;
        @(posedge clk_in);
        #1;
        // a second valid issue while busy must be ignored
        start_in = slow_m && vl > 8;
        check(busy_out, 1'b1);
        @(posedge clk_in);
        #1;
        start_in = 1'b0;
        // look mid-cycle so the one-cycle done pulse is seen settled
        for (w = 0; w < 2000 && done_out !== 1'b1; w++) @(negedge clk_in);
        if (w == 2000) error_cnt++;
        check(busy_out, 1'b0);
        repeat (3) @(posedge clk_in);
        check(n_acc, vl);
        check(ld_n, st ? 0 : vl);
        check(exp_addr.size() + exp_data.size(), 0);
        exp_addr.delete();
        exp_data.delete();
        $display("test %0d finished", test_no);
    endtask : run_op

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(79));
        repeat (10) @(posedge clk_in);
        #1;
        reset_n_in = 1'b1;
        run_op(0, 0, 3'h2, 24'h000100, 24'h000003, 64, 0);
        run_op(0, 0, 3'h5, 24'h000004, 24'hFFFFFE, 20, 1);
        run_op(0, 0, 3'h0, 24'hFFFFF8, 24'h000007, 16, 0);
        run_op(0, 1, 3'h3, 24'h001000, 24'h000000, 64, 1);
        run_op(1, 0, 3'h1, 24'h000200, 24'hFFFFFD, 33, 0);
        run_op(1, 0, 3'h0, 24'h000300, 24'h000005, 1, 1);
        run_op(1, 1, 3'h4, 24'hFFFF00, 24'h000000, 64, 1);
        run_op(1, 0, 3'h1, 24'h000000, 24'h000001, 0, 0);
        repeat (6) run_op($urandom % 2, $urandom % 2, 3'($urandom), 24'($urandom), 24'($urandom),
                          $urandom % 65, $urandom % 2);
        // unknown major code: no activity at all
        @(posedge clk_in);
        #1;
        n_acc = 0;
        instr_in = 16'h1234;
        start_in = 1'b1;
        @(posedge clk_in);
        #1;
        start_in = 1'b0;
        repeat (6) @(posedge clk_in);
        check(busy_out, 0);
        check(n_acc, 0);
        $display("test %0d finished", test_no + 1);
        results;
    end

    // watchdog: about nine times the expected run length
    initial begin
        #400000;
        error_cnt++;
        results;
    end
endmodule : testbench
`default_nettype wire
